// ---- hdl/cir_command_irq_regs.sv ----
`timescale 1ns/1ps
// command and interrupt-enable registers behind the host subaddress port
module cir_command_irq_regs #(
    parameter int WAKE_LEN = cir_pkg::WAKE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [5:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    input wire logic [cir_pkg::IRQ_SOURCES-1:0] IRQ_FLAGS,
    input wire logic CMD_DONE,
    output logic [3:0] COMMAND_CODE,
    output logic COMMAND_START,
    output logic IDLE_IRQ_SET,
    output logic RECEIVER_OFF,
    output logic SOFT_POWER_DOWN,
    output logic IRQ
);
    import cir_pkg::*;

    logic rst_meta;
    logic rst_n;
    cir_pd_state_t pd_state;
    cir_pd_state_t next_pd_state;
    logic [3:0] next_command_code;
    logic next_command_start;
    logic next_idle_irq_set;
    logic next_receiver_off;
    logic next_soft_power_down;
    logic [7:0] irq_enable_primary;
    logic [7:0] next_irq_enable_primary;
    logic [7:0] next_rd_data;
    logic next_irq;
    logic wake_start;
    logic wake_done;
    logic wr_cmd;
    logic wr_ien;
    logic pd_read;

    // reset release through two flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // address decode
    always_comb begin
        wr_cmd = WR_EN && (ADDR == ADDR_COMMAND_CONTROL);
        wr_ien = WR_EN && (ADDR == ADDR_IRQ_ENABLE_PRIMARY);
    end

    assign pd_read = (pd_state != PD_AWAKE); // one while down or still waking

    // command field, receiver switch and power-down sequence
    always_comb begin
        next_command_code = COMMAND_CODE;
        next_command_start = 1'b0;
        next_idle_irq_set = 1'b0;
        next_receiver_off = RECEIVER_OFF;
        next_pd_state = pd_state;
        wake_start = 1'b0;
        if (CMD_DONE && COMMAND_CODE != CMD_IDLE) begin
            next_command_code = CMD_IDLE;
            next_idle_irq_set = 1'b1;
        end
        if (pd_state == PD_WAKING && wake_done) begin
            next_pd_state = PD_AWAKE;
        end
        if (wr_cmd) begin
            next_receiver_off = WR_DATA[RECEIVER_OFF_BIT];
            if (cmd_known(WR_DATA[COMMAND_MSB:0])) begin
                next_command_code = WR_DATA[COMMAND_MSB:0];
                next_command_start = 1'b1;
                next_idle_irq_set = 1'b0;
            end else begin
                next_command_code = CMD_IDLE;
                next_idle_irq_set = 1'b1;
                next_command_start = 1'b0;
            end
            if (WR_DATA[SOFT_POWER_DOWN_BIT]) begin
                if (COMMAND_CODE != CMD_SOFT_RESET
                        && WR_DATA[COMMAND_MSB:0] != CMD_SOFT_RESET) begin
                    next_pd_state = PD_DOWN;
                end
            end else if (pd_state == PD_DOWN) begin
                next_pd_state = PD_WAKING;
                wake_start = 1'b1;
            end
        end
        next_soft_power_down = (next_pd_state != PD_AWAKE);
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            COMMAND_CODE <= RESET_COMMAND_CONTROL[COMMAND_MSB:0];
            COMMAND_START <= 1'b0;
            IDLE_IRQ_SET <= 1'b0;
            RECEIVER_OFF <= RESET_COMMAND_CONTROL[RECEIVER_OFF_BIT];
            SOFT_POWER_DOWN <= RESET_COMMAND_CONTROL[SOFT_POWER_DOWN_BIT];
            pd_state <= PD_AWAKE;
        end else begin
            COMMAND_CODE <= next_command_code;
            COMMAND_START <= next_command_start;
            IDLE_IRQ_SET <= next_idle_irq_set;
            RECEIVER_OFF <= next_receiver_off;
            SOFT_POWER_DOWN <= next_soft_power_down;
            pd_state <= next_pd_state;
        end
    end

    // wake-up delay
    cir_wake_timer #(.CYCLES(WAKE_LEN)) u_wake (
        .clk(CLK),
        .rst_n(rst_n),
        .start(wake_start),
        .done(wake_done)
    );

    // interrupt enables and IRQ pin level
    always_comb begin
        next_irq_enable_primary = irq_enable_primary;
        if (wr_ien) begin
            next_irq_enable_primary = WR_DATA;
        end
        next_irq = (|(IRQ_FLAGS & irq_enable_primary[IRQ_SOURCES-1:0]))
            ^ irq_enable_primary[IRQ_OUTPUT_INVERT_BIT];
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_primary <= RESET_IRQ_ENABLE_PRIMARY;
            IRQ <= RESET_IRQ_ENABLE_PRIMARY[IRQ_OUTPUT_INVERT_BIT];
        end else begin
            irq_enable_primary <= next_irq_enable_primary;
            IRQ <= next_irq;
        end
    end

    // read data, zero for reserved and unmapped subaddresses
    always_comb begin
        next_rd_data = RD_DATA;
        if (RD_EN) begin
            if (ADDR == ADDR_COMMAND_CONTROL) begin
                next_rd_data = {2'b00, RECEIVER_OFF, pd_read, COMMAND_CODE};
            end else if (ADDR == ADDR_IRQ_ENABLE_PRIMARY) begin
                next_rd_data = irq_enable_primary;
            end else begin
                next_rd_data = RESET_RESERVED_ZERO;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RD_DATA <= 8'h00;
        end else begin
            RD_DATA <= next_rd_data;
        end
    end

    // checks
    a_reserved_reads_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        RD_EN && ADDR == ADDR_RESERVED_ZERO |=> RD_DATA == 8'h00)
        else $error("reserved register did not read zero");
    a_cmd_top_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        RD_EN && ADDR == ADDR_COMMAND_CONTROL |=> RD_DATA[7:6] == 2'b00)
        else $error("command bits 7:6 not zero");
    a_cmd_read_running: assert property (@(posedge CLK) disable iff (!rst_n)
        RD_EN && ADDR == ADDR_COMMAND_CONTROL
        |=> RD_DATA[3:0] == $past(COMMAND_CODE) && RD_DATA[4] == $past(pd_read))
        else $error("command read does not show running command");
    a_rcv_off_write: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd |=> RECEIVER_OFF == $past(WR_DATA[RECEIVER_OFF_BIT]))
        else $error("receiver_off not taken");
    a_pd_enter: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && WR_DATA[SOFT_POWER_DOWN_BIT] && COMMAND_CODE != CMD_SOFT_RESET
        && WR_DATA[3:0] != CMD_SOFT_RESET |=> SOFT_POWER_DOWN && pd_state == PD_DOWN)
        else $error("power-down not entered");
    a_pd_blocked: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && WR_DATA[SOFT_POWER_DOWN_BIT] && COMMAND_CODE == CMD_SOFT_RESET
        && pd_state == PD_AWAKE |=> !SOFT_POWER_DOWN)
        else $error("power-down set during soft reset");
    a_wake_holds_one: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && !WR_DATA[SOFT_POWER_DOWN_BIT] && pd_state == PD_DOWN
        |=> pd_read[*8] ##[1:300] !pd_read)
        else $error("wake-up bit behaviour wrong");
    a_cmd_start: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && cmd_known(WR_DATA[3:0])
        |=> COMMAND_START && COMMAND_CODE == $past(WR_DATA[3:0]))
        else $error("known command not started");
    a_unknown_idle: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && !cmd_known(WR_DATA[3:0])
        |=> COMMAND_CODE == CMD_IDLE && IDLE_IRQ_SET && !COMMAND_START)
        else $error("unknown command not turned to idle");
    a_done_idle: assert property (@(posedge CLK) disable iff (!rst_n)
        CMD_DONE && !wr_cmd && COMMAND_CODE != CMD_IDLE
        |=> COMMAND_CODE == CMD_IDLE && IDLE_IRQ_SET)
        else $error("finished command not returned to idle");
    a_ien_write: assert property (@(posedge CLK) disable iff (!rst_n)
        wr_ien |=> irq_enable_primary == $past(WR_DATA))
        else $error("interrupt enable not written");
    a_irq_level: assert property (@(posedge CLK) disable iff (!rst_n)
        1'b1 |=> IRQ == ((|($past(IRQ_FLAGS) & $past(irq_enable_primary[6:0])))
        ^ $past(irq_enable_primary[7])))
        else $error("IRQ level wrong");
    a_reserved_write: assert property (@(posedge CLK) disable iff (!rst_n)
        WR_EN && ADDR != ADDR_COMMAND_CONTROL && ADDR != ADDR_IRQ_ENABLE_PRIMARY
        |=> $stable(irq_enable_primary) && $stable(COMMAND_CODE) || $past(CMD_DONE))
        else $error("reserved write changed state");

    c_wake_cycle: cover property (@(posedge CLK) disable iff (!rst_n)
        pd_state == PD_WAKING ##[1:300] pd_state == PD_AWAKE);
    c_unknown_cmd: cover property (@(posedge CLK) disable iff (!rst_n)
        wr_cmd && !cmd_known(WR_DATA[3:0]));
    c_irq_assert: cover property (@(posedge CLK) disable iff (!rst_n)
        $changed(IRQ));
endmodule // cir_command_irq_regs

// ---- pkg/cir_pkg.sv ----
// Overview of operation
// - command_control sits at 01h, resets to 20h; bits 7 and 6 read zero.
// - bit 5 receiver_off is read/write and switches off the analog receiver.
// - writing one to bit 4 enters soft power-down.
// - clearing bit 4 starts wake-up; bit reads one until ready; host polls it.
// - setting power-down is ignored while the soft reset command is active.
// - writing the command field starts the command with that code.
// - reading the command field returns the command now executing.
// - irq_enable_primary at 02h, resets to 80h, all bits read/write, invert plus enables.
// - register 00h is reserved, resets to 00h and does nothing.
// - unknown command code returns field to idle and raises the idle request.
// - each enable bit lets its request flag reach the IRQ output.
// - invert bit one drives IRQ inverted, zero drives it straight.
package cir_pkg;
    // register subaddresses
    localparam logic [5:0] ADDR_RESERVED_ZERO = 6'h00;
    localparam logic [5:0] ADDR_COMMAND_CONTROL = 6'h01;
    localparam logic [5:0] ADDR_IRQ_ENABLE_PRIMARY = 6'h02;
    localparam logic [5:0] ADDR_PROD_TEST_FIRST = 6'h3C;
    // reset values
    localparam logic [7:0] RESET_RESERVED_ZERO = 8'h00;
    localparam logic [7:0] RESET_COMMAND_CONTROL = 8'h20;
    localparam logic [7:0] RESET_IRQ_ENABLE_PRIMARY = 8'h80;
    // command_control fields
    localparam int RECEIVER_OFF_BIT = 5;
    localparam int SOFT_POWER_DOWN_BIT = 4;
    localparam int COMMAND_MSB = 3;
    // irq_enable_primary fields
    localparam int IRQ_OUTPUT_INVERT_BIT = 7;
    localparam int IRQ_SOURCES = 7;
    // command codes
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [3:0] CMD_SOFT_RESET = 4'hF;
    localparam logic [15:0] CMD_KNOWN_MASK = 16'h80FF;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // power-down state
    typedef enum logic [1:0] {PD_AWAKE, PD_DOWN, PD_WAKING} cir_pd_state_t;

    // true when the code selects a command the core can run
    function automatic logic cmd_known(input logic [3:0] code);
        return CMD_KNOWN_MASK[code];
    endfunction
endpackage

// ---- hdl/cir_wake_timer.sv ----
`timescale 1ns/1ps
// counts the wake-up delay after soft power-down is left
module cir_wake_timer #(
    parameter int CYCLES = cir_pkg::WAKE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic done
);
    import cir_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam int SW = CW + 1;
    localparam logic [SW-1:0] WAKE_END = SW'(CYCLES + 1); // sampled edges from start to done

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_done;
    logic [SW-1:0] since_start;
    logic [SW-1:0] next_since_start;

    // load on start, count down, pulse done on reaching zero
    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (start) begin
            next_count = LOAD;
        end else if (count != '0) begin
            next_count = count - CW'(1);
            next_done = (count == CW'(1));
        end
        // independent edge count since start, clears to zero and stays there once done is due
        next_since_start = since_start;
        if (start) begin
            next_since_start = SW'(1);
        end else if (since_start == WAKE_END) begin
            next_since_start = '0;
        end else if (since_start != '0) begin
            next_since_start = since_start + SW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            done <= 1'b0;
            since_start <= '0;
        end else begin
            count <= next_count;
            done <= next_done;
            since_start <= next_since_start;
        end
    end

    // done must show exactly when the independent count reaches its end
    a_wake_length: assert property (@(posedge clk) disable iff (!rst_n)
        done == (since_start == WAKE_END))
        else $error("wake-up delay has wrong length");
endmodule // cir_wake_timer

// ---- verification/cir_engine_model.sv ----
`timescale 1ns/1ps
// command engine stand-in: finishes a started command after a delay
module cir_engine_model #(
    parameter int DELAY = 6
) (
    input wire logic clk,
    input wire logic stall,
    input wire logic start,
    input wire logic [3:0] code,
    output logic done
);
    int cnt = 0;
    initial done = 1'b0;
    // count down unless stalled, pulse done once at the end
    always @(posedge clk) begin
        if (start && code != 4'h0) begin
            cnt <= DELAY;
            done <= 1'b0;
        end else if (cnt > 0 && !stall) begin
            cnt <= cnt - 1;
            done <= (cnt == 1);
        end else begin
            done <= 1'b0;
        end
    end
endmodule // cir_engine_model

// ---- verification/command_irq_enable_regs_tb.sv ----
`timescale 1ns/1ps
module command_irq_enable_regs_tb;
    import cir_pkg::*;
    logic clk = 0, resetn = 0, wr_en = 0, rd_en = 0, stall = 0, cmd_done;
    logic [5:0] addr = 6'h00;
    logic [7:0] wr_data = 8'h00, rd_data, rv;
    logic [6:0] irq_flags = 7'h00;
    logic [3:0] command_code;
    logic command_start, idle_irq_set, receiver_off, soft_power_down, irq;
    int mismatches = 0, num_checks = 0, cycles = 0;

    // 10 MHz core clock
    always #50 clk = ~clk;

    cir_command_irq_regs #(.WAKE_LEN(10)) i_dut (.CLK(clk), .RESETN(resetn), .ADDR(addr),
        .WR_EN(wr_en), .RD_EN(rd_en), .WR_DATA(wr_data), .RD_DATA(rd_data),
        .IRQ_FLAGS(irq_flags), .CMD_DONE(cmd_done), .COMMAND_CODE(command_code),
        .COMMAND_START(command_start), .IDLE_IRQ_SET(idle_irq_set),
        .RECEIVER_OFF(receiver_off), .SOFT_POWER_DOWN(soft_power_down), .IRQ(irq));
    cir_engine_model i_eng (.clk(clk), .stall(stall), .start(command_start),
        .code(command_code), .done(cmd_done));

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one register write, effect visible on return
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        if (a >= ADDR_PROD_TEST_FIRST) return; // host keeps out of production test range
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    // one register read
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // bounded wait for the command field to fall back to idle
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            if (command_code === CMD_IDLE) break;
            @(posedge clk);
            #1;
        end
    endtask

    task automatic t_reset();
        rd(ADDR_RESERVED_ZERO, rv);
        chk(rv, 8'h00, "reset 00h");
        rd(ADDR_COMMAND_CONTROL, rv);
        chk(rv, 8'h20, "reset 01h");
        rd(ADDR_IRQ_ENABLE_PRIMARY, rv);
        chk(rv, 8'h80, "reset 02h");
        chk(irq, 1'b1, "irq inverted idle");
        chk(receiver_off, 1'b1, "receiver off at reset");
        // production test range 3Ch..3Fh is never touched by the host
        wr(ADDR_RESERVED_ZERO, 8'hFF);
        rd(ADDR_RESERVED_ZERO, rv);
        chk(rv, 8'h00, "reserved write dropped");
        wr(6'h10, 8'hFF);
        rd(6'h10, rv);
        chk(rv, 8'h00, "unmapped reads zero");
        wr(ADDR_COMMAND_CONTROL, 8'hC3);
        rd(ADDR_COMMAND_CONTROL, rv);
        chk(rv, 8'h03, "top bits read zero");
        wait_idle();
        $display("t_reset done");
    endtask

    task automatic t_cmd();
        for (int c = 0; c < 15; c++) begin
            wr(ADDR_COMMAND_CONTROL, {4'h0, c[3:0]});
            chk(command_start, c < 8, "start pulse");
            chk(idle_irq_set, c >= 8, "unknown idle request");
            chk(command_code, (c < 8) ? c[3:0] : 4'h0, "code field");
            wait_idle();
            chk(command_code, 4'h0, "back to idle");
            chk(idle_irq_set, c != 0, "idle request at end");
        end
        wr(ADDR_COMMAND_CONTROL, 8'h03);
        @(posedge clk);
        stall <= 1'b1;
        repeat (10) @(posedge clk);
        rd(ADDR_COMMAND_CONTROL, rv);
        chk(rv, 8'h03, "running code read");
        @(posedge clk);
        stall <= 1'b0;
        wait_idle();
        rd(ADDR_COMMAND_CONTROL, rv);
        chk(rv, 8'h00, "finished code read");
        $display("t_cmd done");
    endtask

    task automatic t_pd();
        int i;
        wr(ADDR_COMMAND_CONTROL, 8'h20);
        chk(receiver_off, 1'b1, "receiver off set");
        wr(ADDR_COMMAND_CONTROL, 8'h10);
        chk(receiver_off, 1'b0, "receiver off clear");
        chk(soft_power_down, 1'b1, "power down entered");
        wr(ADDR_COMMAND_CONTROL, 8'h00);
        rd(ADDR_COMMAND_CONTROL, rv);
        chk(rv, 8'h10, "waking reads one");
        for (i = 0; i < 20; i++) begin
            rd(ADDR_COMMAND_CONTROL, rv);
            if (rv[4] === 1'b0) break;
        end
        chk(rv, 8'h00, "awake reads zero");
        chk(i >= 4, 1'b1, "wake not too short");
        chk(soft_power_down, 1'b0, "awake output");
        wr(ADDR_COMMAND_CONTROL, 8'h1F);
        chk(soft_power_down, 1'b0, "power down blocked");
        chk(command_code, CMD_SOFT_RESET, "soft reset runs");
        wait_idle();
        chk(command_code, 4'h0, "soft reset ends");
        wr(ADDR_COMMAND_CONTROL, 8'h1F);
        wr(ADDR_COMMAND_CONTROL, 8'h10);
        chk(soft_power_down, 1'b0, "power down blocked while soft reset runs");
        chk(command_code, CMD_IDLE, "idle write stops soft reset");
        $display("t_pd done");
    endtask

    task automatic t_irq();
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h7F);
            @(posedge clk);
            irq_flags <= 7'h01 << i;
            repeat (2) @(posedge clk);
            #1;
            chk(irq, 1'b1, "enabled request");
            wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h7F ^ (8'h01 << i));
            repeat (2) @(posedge clk);
            #1;
            chk(irq, 1'b0, "masked request");
        end
        wr(ADDR_IRQ_ENABLE_PRIMARY, 8'hFF);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 1'b0, "inverted request");
        rd(ADDR_IRQ_ENABLE_PRIMARY, rv);
        chk(rv, 8'hFF, "enables read back");
        @(posedge clk);
        irq_flags <= 7'h00;
        $display("t_irq done");
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_cmd();
        t_pd();
        t_irq();
        wrap_up();
    end
endmodule // command_irq_enable_regs_tb
